//--- dcps_audio_src.sv
// audio source model: word strobe, frame strobe and sample words
// assumes the block's mclk; one word every PER cycles, WPF words a frame
`timescale 1ns/10ps

module dcps_audio_src
#(
   parameter PER = 4, // cycles per word
   parameter WPF = 8  // words per frame
)
(
   input  wire        mclk,        // system clock
   input  wire        reset,       // sync reset
   input  wire [23:0] l_in,        // next left sample
   input  wire [23:0] r_in,        // next right sample
   output reg         word_tick,   // word strobe
   output reg         frame_start, // frame strobe
   output reg  [23:0] left_word,   // left sample
   output reg  [23:0] right_word   // right sample
);
   reg  [3:0] cyc_r;
   reg  [3:0] wrd_r;
   wire       last_w = (cyc_r == PER - 1);

   // words are valid in the strobe cycle only; otherwise the lines
   // toggle so that a late sample in the block shows as wrong data
   always @(posedge mclk)
   begin
      cyc_r       <= (reset || last_w) ? 4'h0 : cyc_r + 4'h1;
      wrd_r       <= (reset || (last_w && wrd_r == WPF - 1)) ? 4'h0 : wrd_r + {3'h0, last_w};
      word_tick   <= !reset && last_w;
      frame_start <= !reset && last_w && wrd_r == 4'h0;
      left_word   <= last_w ? l_in : ~left_word;
      right_word  <= last_w ? r_in : ~right_word;
   end
endmodule // dcps_audio_src

//--- dcps_dc_detect.v
// constant-input detector driving the automatic mute
// assumes sample_tick marks each new sample on sample_in
`timescale 1ns/10ps
`include "dcps_defs.vh"

module dcps_dc_detect
#(
   parameter DATA_W = 24,
   parameter CNT_W  = 12
)
(
   input  wire              mclk,        // system clock
   input  wire              reset,       // sync reset, active high
   input  wire              sample_tick, // new sample strobe
   input  wire [DATA_W-1:0] sample_in,   // sample before muting
   input  wire [2:0]        am_code,     // auto-mute code
   output reg               auto_mute_r  // automatic mute active
);

reg  [DATA_W-1:0] last_r;   // previous sample
reg  [CNT_W-1:0]  same_r;   // repeats after the first of a run
reg  [CNT_W-1:0]  thresh;
reg               am_on;
wire              same;

assign same = (sample_in == last_r);

// threshold lookup; code 000 and code 111 disable muting
always @*
begin
   thresh = {CNT_W{1'b1}};
   am_on  = 1'b1;
   case (am_code)
      `DCPS_AM_100:  thresh = `DCPS_TH_100;
      `DCPS_AM_200:  thresh = `DCPS_TH_200;
      `DCPS_AM_400:  thresh = `DCPS_TH_400;
      `DCPS_AM_800:  thresh = `DCPS_TH_800;
      `DCPS_AM_1600: thresh = `DCPS_TH_1600;
      `DCPS_AM_3200: thresh = `DCPS_TH_3200;
      default:       am_on  = 1'b0;
   endcase
end

// mute once run length exceeds threshold (same count reaches it)
always @(posedge mclk)
begin
   if (reset)
   begin
      last_r      <= {DATA_W{1'b0}};
      same_r      <= {CNT_W{1'b0}};
      auto_mute_r <= 1'b0;
   end
   else
   begin
      if (sample_tick)
      begin
         last_r <= sample_in;
         if (!same)
            same_r <= {CNT_W{1'b0}};
         else if (same_r != {CNT_W{1'b1}})
            same_r <= same_r + {{(CNT_W-1){1'b0}}, 1'b1};
      end
      if (!am_on)
         auto_mute_r <= 1'b0;
      else if (sample_tick && !same)
         auto_mute_r <= 1'b0;
      else
         auto_mute_r <= (same_r >= thresh);
   end
end

endmodule // dcps_dc_detect

//--- dcps_defs.vh
// named constants for the playback channel setup block
// assumes inclusion by bare name from each design file
`ifndef DCPS_DEFS_VH
`define DCPS_DEFS_VH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define DCPS_IDX_RSVD_SLOT     8'h3D
`define DCPS_IDX_ENGINE_CFG    8'h3E
`define DCPS_IDX_SETUP_ONE     8'h3F
`define DCPS_IDX_MUTE_SETUP    8'h40
`define DCPS_ADDR_LSB          2

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define DCPS_CFG_FLAG_A        2
`define DCPS_CFG_FLAG_B        1
`define DCPS_CFG_CTR_HOLD      0
`define DCPS_S1_POWER          7
`define DCPS_S1_SRC_HI         5
`define DCPS_S1_SRC_LO         4
`define DCPS_S1_STEP_HI        1
`define DCPS_S1_STEP_LO        0
`define DCPS_MS_AM_HI          6
`define DCPS_MS_AM_LO          4
`define DCPS_MS_MUTE           3
`define DCPS_MS_SPARE_HI       1
`define DCPS_MS_SPARE_LO       0

// ---------------------------------------------------------------
// reset values and fixed read values of reserved bits
// ---------------------------------------------------------------
`define DCPS_RST_RSVD_SLOT     8'h00
`define DCPS_RST_CFG_BIT       1'b0
`define DCPS_RST_POWER         1'b0
`define DCPS_RST_SRC           2'h1
`define DCPS_RST_STEP          2'h0
`define DCPS_RST_AM            3'h0
`define DCPS_RST_MUTE          1'b1
`define DCPS_RST_SPARE         2'h0
`define DCPS_S1_RSVD_RD        2'h1
`define DCPS_MS_RSVD_RD        1'b1

// ---------------------------------------------------------------
// source select and soft-step codes
// ---------------------------------------------------------------
`define DCPS_SRC_OFF           2'h0
`define DCPS_SRC_LEFT          2'h1
`define DCPS_SRC_RIGHT         2'h2
`define DCPS_SRC_MONO          2'h3
`define DCPS_STEP_EVERY        2'h0
`define DCPS_STEP_EVERY2       2'h1
`define DCPS_STEP_NONE         2'h2

// ---------------------------------------------------------------
// auto-mute codes and thresholds in samples
// ---------------------------------------------------------------
`define DCPS_AM_OFF            3'h0
`define DCPS_AM_100            3'h1
`define DCPS_AM_200            3'h2
`define DCPS_AM_400            3'h3
`define DCPS_AM_800            3'h4
`define DCPS_AM_1600           3'h5
`define DCPS_AM_3200           3'h6
`define DCPS_TH_100            12'h064
`define DCPS_TH_200            12'h0C8
`define DCPS_TH_400            12'h190
`define DCPS_TH_800            12'h320
`define DCPS_TH_1600           12'h640
`define DCPS_TH_3200           12'hC80

`endif

//--- dcps_soft_step.v
// volume soft-stepper: walks the applied volume toward the target
// assumes word_tick is a one-cycle pulse per audio word clock
`timescale 1ns/10ps
`include "dcps_defs.vh"

module dcps_soft_step
#(
   parameter VOL_W = 8
)
(
   input  wire             mclk,       // system clock
   input  wire             reset,      // sync reset, active high
   input  wire             word_tick,  // one pulse per word clock
   input  wire [1:0]       step_mode,  // soft-step code
   input  wire [VOL_W-1:0] vol_target, // wanted volume, signed half-dB
   output reg  [VOL_W-1:0] vol_now_r   // applied volume
);

reg  half_r;    // alternates for one step per two word clocks
wire step_ok;   // a step may be taken this cycle
wire go_up;

// reserved code 11 steps like 00, so a bad write cannot stall volume
assign step_ok = word_tick & ((step_mode != `DCPS_STEP_EVERY2) | half_r);
assign go_up   = $signed(vol_target) > $signed(vol_now_r);

always @(posedge mclk)
begin
   if (reset)
   begin
      vol_now_r <= {VOL_W{1'b0}};
      half_r    <= 1'b0;
   end
   else
   begin
      if (word_tick)
         half_r <= ~half_r;
      if (step_mode == `DCPS_STEP_NONE)
         vol_now_r <= vol_target;
      else if (step_ok && (vol_target != vol_now_r))
      begin
         if (go_up)
            vol_now_r <= vol_now_r + {{(VOL_W-1){1'b0}}, 1'b1};
         else
            vol_now_r <= vol_now_r - {{(VOL_W-1){1'b0}}, 1'b1};
      end
   end
end

endmodule // dcps_soft_step

//--- dcps_top.v
// playback channel setup and control, top level with APB register slave
// assumes all inputs synchronous to mclk; word_tick and frame_start are pulses
// sample words are read only in the word_tick cycle
//
// Chosen here: register access over APB.
`timescale 1ns/10ps
`include "dcps_defs.vh"

module dcps_top
#(
   parameter DATA_W = 24,
   parameter VOL_W  = 8,
   parameter PC_W   = 10,
   parameter CNT_W  = 12
)
(
   input  wire              mclk,          // system clock, 10 MHz
   input  wire              reset,         // sync reset, active high
   input  wire              psel,          // APB select
   input  wire              penable,       // APB access phase
   input  wire              pwrite,        // APB direction, 1 write
   input  wire [11:0]       paddr,         // APB byte address
   input  wire [31:0]       pwdata,        // APB write data
   output reg  [31:0]       prdata,        // APB read data
   output reg               pready,        // APB ready
   output reg               pslverr,       // APB error, unmapped
   input  wire              word_tick,     // one pulse per word clock
   input  wire              frame_start,   // one pulse per new frame
   input  wire              instr_step,    // engine executed one instruction
   input  wire [DATA_W-1:0] left_word,     // received left sample
   input  wire [DATA_W-1:0] right_word,    // received right sample
   input  wire [VOL_W-1:0]  vol_target,    // volume setting, signed half-dB
   output reg               flag_a_r,      // branch condition A
   output reg               flag_b_r,      // branch condition B
   output reg  [PC_W-1:0]   instr_count_r, // engine instruction counter
   output reg               chan_power_r,  // channel powered up
   output reg  [DATA_W-1:0] chan_data_r,   // channel data after mute
   output reg               chan_mute_r,   // channel muted, any cause
   output wire [VOL_W-1:0]  vol_applied_r  // soft-stepped volume
);

// ---------------------------------------------------------------
// register state
// ---------------------------------------------------------------
// word map, low byte lane only:
// 3D reserved, reads zero, writes dropped
// 3E [2] flag A, [1] flag B, [0] hold
// 3F [7] power, [6] zero, [5:4] source,
//    [3:2] fixed 01, [1:0] soft-step
// 40 [7] zero, [6:4] auto-mute code,
//    [3] forced mute, [2] fixed one,
//    [1:0] spare, read and write
// upper bytes of pwdata are ignored and
// prdata[31:8] always reads zero
// fixed fields are not stored, so a bad
// write there cannot reach the logic

reg              ctr_hold_r;    // keep counter across frames
reg              power_bit_r;   // software power request
reg  [1:0]       src_sel_r;     // source select field
reg  [1:0]       step_mode_r;   // soft-step field
reg  [2:0]       am_code_r;     // auto-mute field
reg              mute_bit_r;    // forced mute
reg  [1:0]       spare_r;       // read/write spare bits of mute setup

// ---------------------------------------------------------------
// bus decode
// ---------------------------------------------------------------
wire [9:0]       word_idx;      // register index from byte address
wire             aligned;
wire             setup_ph;
wire             write_go;
reg              hit;
reg  [7:0]       rd_byte;

// all ten index bits are compared, so
// the words have no aliases in the space
assign word_idx = paddr[11:`DCPS_ADDR_LSB];
assign aligned  = (paddr[`DCPS_ADDR_LSB-1:0] == 2'h0);
assign setup_ph = psel & ~penable;
// a write lands only at the edge where the master sees pready
assign write_go = psel & penable & pready & pwrite & ~pslverr;

// read mux and address hit; reserved bits show their fixed values
// an index off the map, or a byte address
// off a word boundary, answers pslverr
always @*
begin
   hit     = 1'b0;
   rd_byte = 8'h00;
   if (!aligned)
      hit = 1'b0;
   else if (word_idx == {2'h0, `DCPS_IDX_RSVD_SLOT})
   begin
      hit     = 1'b1;
      rd_byte = `DCPS_RST_RSVD_SLOT;
   end
   else if (word_idx == {2'h0, `DCPS_IDX_ENGINE_CFG})
   begin
      hit     = 1'b1;
      rd_byte = {5'h00, flag_a_r, flag_b_r, ctr_hold_r};
   end
   else if (word_idx == {2'h0, `DCPS_IDX_SETUP_ONE})
   begin
      hit     = 1'b1;
      rd_byte = {power_bit_r, 1'b0, src_sel_r, `DCPS_S1_RSVD_RD, step_mode_r};
   end
   else if (word_idx == {2'h0, `DCPS_IDX_MUTE_SETUP})
   begin
      hit     = 1'b1;
      rd_byte = {1'b0, am_code_r, mute_bit_r, `DCPS_MS_RSVD_RD, spare_r};
   end
end

// ---------------------------------------------------------------
// APB handshake
// ---------------------------------------------------------------
// one wait-free access: answer is prepared in the setup cycle so every
// bus output comes from a flop; no wait cycle is added to a transfer
// penable held past ready sees pready low,
// so a write can never land twice
always @(posedge mclk)
begin
   if (reset)
   begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
   end
   else
   begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~hit;
      if (setup_ph)
         prdata <= (hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
   end
end

// ---------------------------------------------------------------
// register writes
// ---------------------------------------------------------------
// the reserved slot ignores writes; it always reads back zero
// unmapped words fall through every
// branch and leave the fields untouched
always @(posedge mclk)
begin
   if (reset)
   begin
      flag_a_r    <= `DCPS_RST_CFG_BIT;
      flag_b_r    <= `DCPS_RST_CFG_BIT;
      ctr_hold_r  <= `DCPS_RST_CFG_BIT;
      power_bit_r <= `DCPS_RST_POWER;
      src_sel_r   <= `DCPS_RST_SRC;
      step_mode_r <= `DCPS_RST_STEP;
      am_code_r   <= `DCPS_RST_AM;
      mute_bit_r  <= `DCPS_RST_MUTE;
      spare_r     <= `DCPS_RST_SPARE;
   end
   else if (write_go)
   begin
      if (word_idx == {2'h0, `DCPS_IDX_ENGINE_CFG})
      begin
         flag_a_r   <= pwdata[`DCPS_CFG_FLAG_A];
         flag_b_r   <= pwdata[`DCPS_CFG_FLAG_B];
         ctr_hold_r <= pwdata[`DCPS_CFG_CTR_HOLD];
      end
      else if (word_idx == {2'h0, `DCPS_IDX_SETUP_ONE})
      begin
         power_bit_r <= pwdata[`DCPS_S1_POWER];
         src_sel_r   <= pwdata[`DCPS_S1_SRC_HI:`DCPS_S1_SRC_LO];
         step_mode_r <= pwdata[`DCPS_S1_STEP_HI:`DCPS_S1_STEP_LO];
      end
      else if (word_idx == {2'h0, `DCPS_IDX_MUTE_SETUP})
      begin
         am_code_r  <= pwdata[`DCPS_MS_AM_HI:`DCPS_MS_AM_LO];
         mute_bit_r <= pwdata[`DCPS_MS_MUTE];
         spare_r    <= pwdata[`DCPS_MS_SPARE_HI:`DCPS_MS_SPARE_LO];
      end
   end
end

// ---------------------------------------------------------------
// instruction counter
// ---------------------------------------------------------------
// wraps at PC_W bits; size it to cover
// the longest program of the engine
// frame restart wins over a step in the same cycle
always @(posedge mclk)
begin
   if (reset)
      instr_count_r <= {PC_W{1'b0}};
   else if (frame_start && !ctr_hold_r)
      instr_count_r <= {PC_W{1'b0}};
   else if (instr_step)
      instr_count_r <= instr_count_r + {{(PC_W-1){1'b0}}, 1'b1};
end

// ---------------------------------------------------------------
// source selection
// ---------------------------------------------------------------
wire [DATA_W:0]   mix_sum;   // one bit wider to keep the carry
reg  [DATA_W-1:0] src_word;

// mono mix is the signed average, halving avoids clipping
// halving floors toward minus infinity;
// the lost half step is below one LSB
assign mix_sum = {left_word[DATA_W-1], left_word} + {right_word[DATA_W-1], right_word};

always @*
begin
   src_word = {DATA_W{1'b0}};
   case (src_sel_r)
      `DCPS_SRC_LEFT:  src_word = left_word;
      `DCPS_SRC_RIGHT: src_word = right_word;
      `DCPS_SRC_MONO:  src_word = mix_sum[DATA_W:1];
      default:         src_word = {DATA_W{1'b0}};
   endcase
end

// ---------------------------------------------------------------
// auto-mute and volume helpers
// ---------------------------------------------------------------
// the dc detector sees the selected word, so a
// silent source can auto-mute the channel
wire auto_mute;

dcps_dc_detect
#(
   .DATA_W (DATA_W),
   .CNT_W  (CNT_W)
)
u_dc_detect
(
   .mclk        (mclk),
   .reset       (reset),
   .sample_tick (word_tick),
   .sample_in   (src_word),
   .am_code     (am_code_r),
   .auto_mute_r (auto_mute)
);

dcps_soft_step
#(
   .VOL_W (VOL_W)
)
u_soft_step
(
   .mclk       (mclk),
   .reset      (reset),
   .word_tick  (word_tick),
   .step_mode  (step_mode_r),
   .vol_target (vol_target),
   .vol_now_r  (vol_applied_r)
);

// ---------------------------------------------------------------
// channel outputs
// ---------------------------------------------------------------
// unmuted data is loaded on the word tick only, so it stays steady between words;
// muted or unpowered channel sends zeros, the safe value for the amplifier
// flag and zeroed data rise at one edge:
// unmuted data never shows with flag set
// power-down zeros the data on the next
// clock rather than waiting for a word
always @(posedge mclk)
begin
   if (reset)
   begin
      chan_power_r <= `DCPS_RST_POWER;
      chan_mute_r  <= `DCPS_RST_MUTE;
      chan_data_r  <= {DATA_W{1'b0}};
   end
   else
   begin
      chan_power_r <= power_bit_r;
      chan_mute_r  <= mute_bit_r | auto_mute;
      if (!power_bit_r || mute_bit_r || auto_mute)
         chan_data_r <= {DATA_W{1'b0}};
      else if (word_tick)
         chan_data_r <= src_word;
   end
end

endmodule // dcps_top

//--- dcps_top_assertions.sv
// checker for the playback channel setup block
// assumes it is bound onto dcps_top; one clock domain, mclk
`timescale 1ns/10ps

module dcps_chk
#(
   parameter PC_W = 10
)
(
   input wire            mclk,          // system clock
   input wire            reset,         // sync reset
   input wire            psel,          // apb select
   input wire            penable,       // apb access phase
   input wire            pwrite,        // apb direction
   input wire [11:0]     paddr,         // apb address
   input wire [31:0]     pwdata,        // apb write data
   input wire [31:0]     prdata,        // apb read data
   input wire            pready,        // apb ready
   input wire            pslverr,       // apb error
   input wire            frame_start,   // frame pulse
   input wire            instr_step,    // instruction pulse
   input wire            flag_a_r,      // branch flag a
   input wire            flag_b_r,      // branch flag b
   input wire [PC_W-1:0] instr_count_r, // instruction counter
   input wire            chan_power_r,  // channel power
   input wire            chan_mute_r    // channel mute
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   property p_flags;
      psel && penable && pready && pwrite && paddr == 12'h0F8
      |=> flag_a_r == $past(pwdata[2]) && flag_b_r == $past(pwdata[1]);
   endproperty
   a_flags: assert property (p_flags) else $error("flags not loaded");

   property p_power;
      psel && penable && pready && pwrite && paddr == 12'h0FC
      |=> ##1 chan_power_r == $past(pwdata[7], 2);
   endproperty
   a_power: assert property (p_power) else $error("power bit not followed");

   property p_count_inc;
      !frame_start && instr_step |=> instr_count_r == $past(instr_count_r) + 1'b1;
   endproperty
   a_count_inc: assert property (p_count_inc) else $error("counter did not step");

   property p_count_idle;
      !frame_start && !instr_step |=> $stable(instr_count_r);
   endproperty
   a_count_idle: assert property (p_count_idle) else $error("counter moved");

   property p_reset_state;
      $fell(reset) |-> chan_mute_r && !chan_power_r && !flag_a_r && !flag_b_r;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad reset state");

   // apb answer: one access cycle, one-cycle ready, narrow data on error
   property p_answer;
      psel && !penable |=> pready;
   endproperty
   a_answer: assert property (p_answer) else $error("no ready after setup");

   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ready held");

   property p_err;
      pslverr |-> pready && prdata[31:8] == 24'h000000;
   endproperty
   a_err: assert property (p_err) else $error("error without ready");
endmodule // dcps_chk

bind dcps_top dcps_chk #(.PC_W(PC_W)) chk (.mclk(mclk), .reset(reset), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .frame_start(frame_start), .instr_step(instr_step),
   .flag_a_r(flag_a_r), .flag_b_r(flag_b_r), .instr_count_r(instr_count_r),
   .chan_power_r(chan_power_r), .chan_mute_r(chan_mute_r));

//--- testbench.sv
// self-checking bench for the playback channel setup block
// assumes the audio source model and the bound checker
`timescale 1ns/10ps
`include "dcps_defs.vh"

module testbench;
   reg         mclk, reset, psel, penable, pwrite, instr_step;
   reg  [11:0] paddr;
   reg  [31:0] pwdata;
   reg  [7:0]  vol_target;
   reg  [23:0] l_in, r_in;
   wire [31:0] prdata;
   wire        pready, pslverr, word_tick, frame_start, flag_a_r, flag_b_r;
   wire        chan_power_r, chan_mute_r;
   wire [23:0] left_word, right_word, chan_data_r;
   wire [9:0]  instr_count_r;
   wire [7:0]  vol_applied_r;
   integer     num_errors, compares, i;
   localparam [11:0] A_RSV = {2'b00, `DCPS_IDX_RSVD_SLOT, 2'b00};
   localparam [11:0] A_CFG = {2'b00, `DCPS_IDX_ENGINE_CFG, 2'b00};
   localparam [11:0] A_S1  = {2'b00, `DCPS_IDX_SETUP_ONE, 2'b00};
   localparam [11:0] A_MS  = {2'b00, `DCPS_IDX_MUTE_SETUP, 2'b00};

   dcps_top uut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .word_tick(word_tick), .frame_start(frame_start), .instr_step(instr_step),
      .left_word(left_word), .right_word(right_word), .vol_target(vol_target),
      .flag_a_r(flag_a_r), .flag_b_r(flag_b_r), .instr_count_r(instr_count_r),
      .chan_power_r(chan_power_r), .chan_data_r(chan_data_r), .chan_mute_r(chan_mute_r),
      .vol_applied_r(vol_applied_r));
   dcps_audio_src src (.mclk(mclk), .reset(reset), .l_in(l_in), .r_in(r_in),
      .word_tick(word_tick), .frame_start(frame_start), .left_word(left_word),
      .right_word(right_word));

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task chk(input [31:0] got, input [31:0] exp, input string nm);
   begin
      compares = compares + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("unexpected %s: expected %0h seen %0h", nm, exp, got);
      end
   end
   endtask

   // one apb transfer; the request stands until ready is sampled high
   task apb(input w, input [11:0] a, input [7:0] d, output [31:0] rd, output e);
      integer n;
   begin
      @(posedge mclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 16)
      begin
         @(posedge mclk);
         n = n + 1;
      end
      chk(n < 16, 1, "ready wait");
      rd = prdata;
      e  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      #1;
   end
   endtask

   task wr(input [11:0] a, input [7:0] d);
      reg [31:0] rd;
      reg        e;
   begin
      apb(1'b1, a, d, rd, e);
   end
   endtask

   task rdc(input [11:0] a, input [31:0] exp, input e_exp, input string nm);
      reg [31:0] rd;
      reg        e;
   begin
      apb(1'b0, a, 8'h00, rd, e);
      chk(rd, exp, nm);
      chk(e, e_exp, "pslverr");
   end
   endtask

   // wait k sampled words, then settle before the next word
   task ticks(input integer k);
   begin
      repeat (k) @(posedge mclk iff word_tick);
      repeat (3) @(posedge mclk);
      #1;
   end
   endtask

   task t_regs;
   begin
      rdc(A_CFG, 32'h00, 1'b0, "engine cfg");
      rdc(A_S1, 32'h14, 1'b0, "setup one");
      rdc(A_MS, 32'h0C, 1'b0, "mute setup");
      rdc(A_RSV, 32'h00, 1'b0, "reserved slot");
      rdc(12'h104, 32'h00, 1'b1, "unmapped");
      chk(chan_mute_r, 1'b1, "reset mute");
      $display("test registers done");
   end
   endtask

   task t_flags;
   begin
      wr(A_CFG, 8'h04);
      chk(flag_a_r, 1'b1, "flag a");
      chk(flag_b_r, 1'b0, "flag b");
      wr(A_CFG, 8'h02);
      chk(flag_a_r, 1'b0, "flag a");
      chk(flag_b_r, 1'b1, "flag b");
      rdc(A_CFG, 32'h02, 1'b0, "engine cfg");
      $display("test flags done");
   end
   endtask

   task t_count;
      reg [9:0] c;
   begin
      @(posedge mclk);
      instr_step <= 1'b1;
      @(posedge mclk iff frame_start);
      #1;
      chk(instr_count_r, 10'h000, "frame clear");
      wr(A_CFG, 8'h01);
      @(posedge mclk iff frame_start);
      c = instr_count_r;
      #1;
      chk(instr_count_r, c + 10'h001, "counter hold");
      @(posedge mclk);
      instr_step <= 1'b0;
      wr(A_CFG, 8'h00);
      $display("test counter done");
   end
   endtask

   // all four source codes, then forced mute and power down
   task t_src;
   begin
      l_in <= 24'h123456;
      r_in <= 24'h020406;
      wr(A_MS, 8'h04);
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(A_S1, 8'h84 + 8'h10 * i);
         ticks(2);
         chk(chan_data_r, i == 0 ? 0 : i == 1 ? 24'h123456 : i == 2 ? 24'h020406
             : 24'h0A1C2E, "source data");
      end
      wr(A_MS, 8'h0C);
      ticks(2);
      chk(chan_mute_r, 1'b1, "forced mute");
      chk(chan_data_r, 0, "muted data");
      wr(A_MS, 8'h04);
      wr(A_S1, 8'h14);
      ticks(2);
      chk(chan_power_r, 1'b0, "power off");
      chk(chan_data_r, 0, "unpowered data");
      wr(A_S1, 8'h94);
      $display("test source done");
   end
   endtask

   task t_vol;
   begin
      wr(A_S1, 8'h96);
      @(posedge mclk);
      vol_target <= 8'h10;
      ticks(1);
      chk(vol_applied_r, 8'h10, "volume at once");
      wr(A_S1, 8'h94);
      @(posedge mclk);
      vol_target <= 8'h14;
      ticks(1);
      chk(vol_applied_r, 8'h11, "one step");
      ticks(3);
      chk(vol_applied_r, 8'h14, "steps done");
      wr(A_S1, 8'h95);
      @(posedge mclk);
      vol_target <= 8'h10;
      ticks(4);
      chk(vol_applied_r, 8'h12, "half rate");
      ticks(4);
      chk(vol_applied_r, 8'h10, "half rate end");
      $display("test soft step done");
   end
   endtask

   // each code: a fresh constant run; codes 1 to 6 mute just past the threshold
   task t_mute;
   begin
      for (i = 0; i < 8; i = i + 1)
      begin
         wr(A_MS, 8'h04 + 8'h10 * i);
         @(posedge mclk iff word_tick);
         l_in <= l_in + 24'h000101;
         ticks((i == 0 || i == 7) ? 120 : 100 << (i - 1));
         chk(chan_mute_r, 1'b0, "below threshold");
         if (i != 0 && i != 7)
         begin
            ticks(1);
            chk(chan_mute_r, 1'b1, "auto mute");
            l_in <= l_in + 24'h000001;
            ticks(2);
            chk(chan_mute_r, 1'b0, "mute lifted");
         end
      end
      $display("test auto mute done");
   end
   endtask

   task print_verdict;
   begin
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask

   // watchdog: the run needs about 28k cycles
   initial
   begin
      #6000000;
      num_errors = num_errors + 1;
      $display("watchdog expired");
      print_verdict;
   end

   initial
   begin
      reset = 1'b1;
      {psel, penable, pwrite, instr_step} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      vol_target = 8'h00;
      l_in = 24'h000000;
      r_in = 24'h000000;
      num_errors = 0;
      compares = 0;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      t_regs;
      t_flags;
      t_count;
      t_src;
      t_vol;
      t_mute;
      print_verdict;
   end
endmodule // testbench
